// file: rtl/port_mux_pkg.sv
// register map, select codes and carrier types of the port function mux
package port_mux_pkg;

  localparam int NUM_PINS = 12;
  localparam int SEL_W = 2;
  localparam int REG_W = 8;
  localparam int NUM_SRC = 4;

  // register indices; the byte address is four times the index
  localparam logic [31:0] IDX_PORT1_HIGH = 32'h0000_52a3;
  localparam logic [31:0] IDX_PORT2_LOW = 32'h0000_52a4;
  localparam logic [31:0] IDX_PORT2_HIGH = 32'h0000_52a5;
  localparam logic [31:0] ADDR_PORT1_HIGH = {IDX_PORT1_HIGH[29:0], 2'b00};
  localparam logic [31:0] ADDR_PORT2_LOW = {IDX_PORT2_LOW[29:0], 2'b00};
  localparam logic [31:0] ADDR_PORT2_HIGH = {IDX_PORT2_HIGH[29:0], 2'b00};
  localparam logic [7:0] RST_SELECT = 8'h00;

  // select codes
  localparam logic [1:0] CODE_PORT = 2'h0;
  localparam logic [1:0] CODE_FN1 = 2'h1;
  localparam logic [1:0] CODE_FN2 = 2'h2;
  localparam logic [1:0] CODE_FN3 = 2'h3;

  // pin slots: fields sit in pin order inside {high2, low2, high1}
  localparam int PIN_PORT1_4 = 0;
  localparam int PIN_PORT1_5 = 1;
  localparam int PIN_PORT1_6 = 2;
  localparam int PIN_PORT1_7 = 3;
  localparam int PIN_PORT2_0 = 4;
  localparam int PIN_PORT2_1 = 5;
  localparam int PIN_PORT2_2 = 6;
  localparam int PIN_PORT2_3 = 7;
  localparam int PIN_PORT2_4 = 8;
  localparam int PIN_PORT2_5 = 9;
  localparam int PIN_PORT2_6 = 10;
  localparam int PIN_PORT2_7 = 11;

  // one bit per legal code, slot 0 at the right
  localparam logic [NUM_PINS-1:0][3:0] VALID_CODES = {
    {4{4'b0011}}, {2{4'b0111}}, {2{4'b1111}}, {4{4'b0111}}
  };

  typedef struct packed {
    logic out;
    logic oe;
  } drive_s;

  typedef struct packed {
    drive_s displayClock;
    drive_s displayTrigger;
    drive_s slaveBusFreeN;
    drive_s twowireMasterClock;
    drive_s twowireMasterData;
    drive_s twowireSlaveClock;
    drive_s twowireSlaveData;
    drive_s serial0Tx;
    drive_s serial0Rx;
    drive_s serial0ExtClock;
    drive_s freqcnt0Input;
    drive_s freqcnt0Reference;
    drive_s freqcnt0SensorA;
    drive_s freqcnt0SensorB;
    drive_s freqcnt1Input;
    drive_s freqcnt1Reference;
    drive_s freqcnt1SensorA;
    drive_s freqcnt1SensorB;
    drive_s buzzerOut;
    drive_s buzzerOutInverted;
  } periph_drive_s;

  typedef struct packed {
    logic displayClock;
    logic displayTrigger;
    logic slaveBusFreeN;
    logic twowireMasterClock;
    logic twowireMasterData;
    logic twowireSlaveClock;
    logic twowireSlaveData;
    logic serial0Tx;
    logic serial0Rx;
    logic serial0ExtClock;
    logic freqcnt0Input;
    logic freqcnt0Reference;
    logic freqcnt0SensorA;
    logic freqcnt0SensorB;
    logic freqcnt1Input;
    logic freqcnt1Reference;
    logic freqcnt1SensorA;
    logic freqcnt1SensorB;
    logic buzzerOut;
    logic buzzerOutInverted;
  } periph_in_s;

endpackage : port_mux_pkg

// file: rtl/pin_route_cell.sv
// one pin: input synchroniser and registered output select
module pin_route_cell #(
  parameter logic [3:0] VALID = 4'b0001
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // selection and sources, slot 0 is the port
  input wire logic [1:0] sel,
  input wire logic [3:0] srcOut,
  input wire logic [3:0] srcOe,
  output logic [1:0] actSel,
  // pin side
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  output logic pinSync
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic out;
    logic oe;
  } cell_state_s;

  cell_state_s s;
  cell_state_s next_s;

  // reserved code falls back to the port
  assign actSel = VALID[sel] ? sel : port_mux_pkg::CODE_PORT;

  always_comb begin
    next_s = s;
    next_s.meta = pinIn;
    next_s.sync = s.meta;
    next_s.out = srcOut[actSel];
    next_s.oe = srcOe[actSel];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pinOut = s.out;
  assign pinOe = s.oe;
  assign pinSync = s.sync;

endmodule : pin_route_cell

// file: rtl/port_function_select_mux.sv
// pin function multiplexer for twelve port pins with apb select registers

// Overview of operation
// - pin 17: display clock, bus-free, port
// - pin 16: master clock, serial tx, port
// - pin 15: master data, serial rx, port
// - pin 14: display trigger, serial clock, port
// - pin 23: counter0 input, master clock, port
// - pin 22: counter0 reference, master data, port
// - pin 21: inverted buzzer, sensor A, slave clock
// - pin 20: buzzer, sensor B, slave data
// - pin 27: counter1 sensor B or port
// - pin 26: counter1 sensor A or port
// - pin 25: counter1 reference or port
// - pin 24: counter1 input or port
// - three 8-bit registers, all fields reset zero
module port_function_select_mux (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // general port side
  input wire logic [11:0] gpioOut,
  input wire logic [11:0] gpioOe,
  output logic [11:0] gpioIn,
  // peripheral side
  input wire port_mux_pkg::periph_drive_s periphDrive,
  output port_mux_pkg::periph_in_s periphIn,
  // package pins
  input wire logic [11:0] pinIn,
  output logic [11:0] pinOut,
  output logic [11:0] pinOe
);

  typedef struct packed {
    logic [7:0] port1High;
    logic [7:0] port2Low;
    logic [7:0] port2High;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    port_mux_pkg::periph_in_s periphIn;
    logic [11:0] gpioIn;
  } top_state_s;

  top_state_s s;
  top_state_s next_s;
  port_mux_pkg::drive_s src [port_mux_pkg::NUM_PINS][port_mux_pkg::NUM_SRC];
  logic [1:0] actSel [port_mux_pkg::NUM_PINS];
  logic [11:0] pinSync;
  logic [23:0] selAll;

  assign selAll = {s.port2High, s.port2Low, s.port1High};

  // source table: slot 0 port, slot n code n
  always_comb begin
    for (int p = 0; p < port_mux_pkg::NUM_PINS; p++) begin
      for (int c = 0; c < port_mux_pkg::NUM_SRC; c++) begin
        src[p][c] = '0;
      end
      src[p][0].out = gpioOut[p];
      src[p][0].oe = gpioOe[p];
    end
    src[port_mux_pkg::PIN_PORT1_7][2] = periphDrive.displayClock;
    src[port_mux_pkg::PIN_PORT1_7][1] = periphDrive.slaveBusFreeN;
    src[port_mux_pkg::PIN_PORT1_6][2] =
      periphDrive.twowireMasterClock;
    src[port_mux_pkg::PIN_PORT1_6][1] = periphDrive.serial0Tx;
    src[port_mux_pkg::PIN_PORT1_5][2] =
      periphDrive.twowireMasterData;
    src[port_mux_pkg::PIN_PORT1_5][1] = periphDrive.serial0Rx;
    src[port_mux_pkg::PIN_PORT1_4][2] =
      periphDrive.displayTrigger;
    src[port_mux_pkg::PIN_PORT1_4][1] =
      periphDrive.serial0ExtClock;
    src[port_mux_pkg::PIN_PORT2_3][2] = periphDrive.freqcnt0Input;
    src[port_mux_pkg::PIN_PORT2_3][1] =
      periphDrive.twowireMasterClock;
    src[port_mux_pkg::PIN_PORT2_2][2] =
      periphDrive.freqcnt0Reference;
    src[port_mux_pkg::PIN_PORT2_2][1] =
      periphDrive.twowireMasterData;
    src[port_mux_pkg::PIN_PORT2_1][3] =
      periphDrive.buzzerOutInverted;
    src[port_mux_pkg::PIN_PORT2_1][2] =
      periphDrive.freqcnt0SensorA;
    src[port_mux_pkg::PIN_PORT2_1][1] =
      periphDrive.twowireSlaveClock;
    src[port_mux_pkg::PIN_PORT2_0][3] = periphDrive.buzzerOut;
    src[port_mux_pkg::PIN_PORT2_0][2] =
      periphDrive.freqcnt0SensorB;
    src[port_mux_pkg::PIN_PORT2_0][1] =
      periphDrive.twowireSlaveData;
    src[port_mux_pkg::PIN_PORT2_7][1] =
      periphDrive.freqcnt1SensorB;
    src[port_mux_pkg::PIN_PORT2_6][1] =
      periphDrive.freqcnt1SensorA;
    src[port_mux_pkg::PIN_PORT2_5][1] =
      periphDrive.freqcnt1Reference;
    src[port_mux_pkg::PIN_PORT2_4][1] = periphDrive.freqcnt1Input;
  end

  for (genvar i = 0; i < port_mux_pkg::NUM_PINS; i++) begin : g_pin
    pin_route_cell #(
      .VALID(port_mux_pkg::VALID_CODES[i])
    ) u_cell (
      .clk(clk),
      .reset(reset),
      .sel(selAll[2*i +: 2]),
      .srcOut({src[i][3].out, src[i][2].out, src[i][1].out, src[i][0].out}),
      .srcOe({src[i][3].oe, src[i][2].oe, src[i][1].oe, src[i][0].oe}),
      .actSel(actSel[i]),
      .pinIn(pinIn[i]),
      .pinOut(pinOut[i]),
      .pinOe(pinOe[i]),
      .pinSync(pinSync[i])
    );
  end

  function automatic logic hit(input int p, input logic [1:0] c);
    hit = pinSync[p] && (actSel[p] == c);
  endfunction : hit

  always_comb begin
    next_s = s;
    next_s.gpioIn = pinSync;
    // inputs reach only the selected peripheral
    next_s.periphIn = '0;
    next_s.periphIn.displayClock = hit(port_mux_pkg::PIN_PORT1_7, 2'h2);
    next_s.periphIn.slaveBusFreeN = hit(port_mux_pkg::PIN_PORT1_7, 2'h1);
    next_s.periphIn.twowireMasterClock =
      hit(port_mux_pkg::PIN_PORT1_6, 2'h2) ||
      hit(port_mux_pkg::PIN_PORT2_3, 2'h1);
    next_s.periphIn.serial0Tx = hit(port_mux_pkg::PIN_PORT1_6, 2'h1);
    next_s.periphIn.twowireMasterData =
      hit(port_mux_pkg::PIN_PORT1_5, 2'h2) ||
      hit(port_mux_pkg::PIN_PORT2_2, 2'h1);
    next_s.periphIn.serial0Rx =
      hit(port_mux_pkg::PIN_PORT1_5, 2'h1);
    next_s.periphIn.displayTrigger = hit(port_mux_pkg::PIN_PORT1_4, 2'h2);
    next_s.periphIn.serial0ExtClock = hit(port_mux_pkg::PIN_PORT1_4, 2'h1);
    next_s.periphIn.freqcnt0Input =
      hit(port_mux_pkg::PIN_PORT2_3, 2'h2);
    next_s.periphIn.freqcnt0Reference = hit(port_mux_pkg::PIN_PORT2_2, 2'h2);
    next_s.periphIn.buzzerOutInverted = hit(port_mux_pkg::PIN_PORT2_1, 2'h3);
    next_s.periphIn.freqcnt0SensorA = hit(port_mux_pkg::PIN_PORT2_1, 2'h2);
    next_s.periphIn.twowireSlaveClock = hit(port_mux_pkg::PIN_PORT2_1, 2'h1);
    next_s.periphIn.buzzerOut = hit(port_mux_pkg::PIN_PORT2_0, 2'h3);
    next_s.periphIn.freqcnt0SensorB = hit(port_mux_pkg::PIN_PORT2_0, 2'h2);
    next_s.periphIn.twowireSlaveData = hit(port_mux_pkg::PIN_PORT2_0, 2'h1);
    next_s.periphIn.freqcnt1SensorB =
      hit(port_mux_pkg::PIN_PORT2_7, 2'h1);
    next_s.periphIn.freqcnt1SensorA = hit(port_mux_pkg::PIN_PORT2_6, 2'h1);
    next_s.periphIn.freqcnt1Reference = hit(port_mux_pkg::PIN_PORT2_5, 2'h1);
    next_s.periphIn.freqcnt1Input =
      hit(port_mux_pkg::PIN_PORT2_4, 2'h1);
    // apb: one wait cycle, then completion
    if (psel && penable && s.pready) begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
      if (pwrite && !s.pslverr && pstrb[0]) begin
        unique case (paddr)
          port_mux_pkg::ADDR_PORT1_HIGH: next_s.port1High = pwdata[7:0];
          port_mux_pkg::ADDR_PORT2_LOW: next_s.port2Low = pwdata[7:0];
          port_mux_pkg::ADDR_PORT2_HIGH: next_s.port2High = pwdata[7:0];
          default: next_s.port1High = s.port1High;
        endcase
      end
    end else if (psel && penable) begin
      next_s.pready = 1'b1;
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h0000_0000;
      unique case (paddr)
        port_mux_pkg::ADDR_PORT1_HIGH: next_s.prdata[7:0] = s.port1High;
        port_mux_pkg::ADDR_PORT2_LOW: next_s.prdata[7:0] = s.port2Low;
        port_mux_pkg::ADDR_PORT2_HIGH: next_s.prdata[7:0] = s.port2High;
        default: next_s.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
      s.port1High <= port_mux_pkg::RST_SELECT;
      s.port2Low <= port_mux_pkg::RST_SELECT;
      s.port2High <= port_mux_pkg::RST_SELECT;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign gpioIn = s.gpioIn;
  assign periphIn = s.periphIn;

  // checks
  property p_route(int p, logic [1:0] c, port_mux_pkg::drive_s d);
    @(posedge clk) disable iff (reset)
    actSel[p] == c |=> pinOut[p] == $past(d.out) && pinOe[p] == $past(d.oe);
  endproperty

  a_p17_display_clk: assert property (p_route(port_mux_pkg::PIN_PORT1_7,
    port_mux_pkg::CODE_FN2, periphDrive.displayClock))
    else $error("pin 17 not on display clock");
  a_p16_serial_tx: assert property (p_route(port_mux_pkg::PIN_PORT1_6,
    port_mux_pkg::CODE_FN1, periphDrive.serial0Tx))
    else $error("pin 16 not on serial tx");
  a_p15_serial_rx: assert property (@(posedge clk) disable iff (reset)
    actSel[port_mux_pkg::PIN_PORT1_5] == port_mux_pkg::CODE_FN1 |=>
    periphIn.serial0Rx == $past(pinSync[port_mux_pkg::PIN_PORT1_5]))
    else $error("serial rx not fed from pin 15");
  a_p14_trigger: assert property (p_route(port_mux_pkg::PIN_PORT1_4,
    port_mux_pkg::CODE_FN2, periphDrive.displayTrigger))
    else $error("pin 14 not on display trigger");
  a_p23_freq_in: assert property (@(posedge clk) disable iff (reset)
    s.port2Low[7:6] == port_mux_pkg::CODE_FN2 |=>
    periphIn.freqcnt0Input == $past(pinSync[port_mux_pkg::PIN_PORT2_3]))
    else $error("counter0 input not fed from pin 23");
  a_p22_master_data: assert property (p_route(port_mux_pkg::PIN_PORT2_2,
    port_mux_pkg::CODE_FN1, periphDrive.twowireMasterData))
    else $error("pin 22 not on master data");
  a_p21_buzzer_inv: assert property (p_route(port_mux_pkg::PIN_PORT2_1,
    port_mux_pkg::CODE_FN3, periphDrive.buzzerOutInverted))
    else $error("pin 21 not on inverted buzzer");
  a_p20_buzzer: assert property (p_route(port_mux_pkg::PIN_PORT2_0,
    port_mux_pkg::CODE_FN3, periphDrive.buzzerOut))
    else $error("pin 20 not on buzzer");
  a_p26_sensor_a: assert property (p_route(port_mux_pkg::PIN_PORT2_6,
    port_mux_pkg::CODE_FN1, periphDrive.freqcnt1SensorA))
    else $error("pin 26 not on counter1 sensor A");
  a_p25_reference: assert property (p_route(port_mux_pkg::PIN_PORT2_5,
    port_mux_pkg::CODE_FN1, periphDrive.freqcnt1Reference))
    else $error("pin 25 not on counter1 reference");
  a_reset_to_port: assert property (@(posedge clk)
    reset ##1 !reset |-> selAll == 24'h00_0000 && !pready ##1
    pinOut == $past(gpioOut) && pinOe == $past(gpioOe))
    else $error("pins not on port after reset");
  a_reserved_port: assert property (@(posedge clk) disable iff (reset)
    s.port2High[7:6] != port_mux_pkg::CODE_FN1 |=>
    pinOut[port_mux_pkg::PIN_PORT2_7] ==
    $past(gpioOut[port_mux_pkg::PIN_PORT2_7]) && !periphIn.freqcnt1SensorB)
    else $error("reserved code left pin 27 off the port");
  a_write_route: assert property (@(posedge clk) disable iff (reset)
    psel && penable && pready && pwrite && pstrb[0] &&
    paddr == port_mux_pkg::ADDR_PORT2_LOW &&
    pwdata[1:0] == port_mux_pkg::CODE_FN3 |=>
    actSel[port_mux_pkg::PIN_PORT2_0] == port_mux_pkg::CODE_FN3 ##1
    pinOut[port_mux_pkg::PIN_PORT2_0] == $past(periphDrive.buzzerOut.out))
    else $error("write did not route pin 20 to buzzer");
  a_apb_one_wait: assert property (@(posedge clk) disable iff (reset)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not after one wait cycle");

  c_write_reg: cover property (@(posedge clk) disable iff (reset)
    psel && penable && pready && pwrite && !pslverr);
  c_unmapped: cover property (@(posedge clk) disable iff (reset)
    pready && pslverr);
  c_buzzer_pin: cover property (@(posedge clk) disable iff (reset)
    actSel[port_mux_pkg::PIN_PORT2_0] == port_mux_pkg::CODE_FN3);

endmodule : port_function_select_mux

// file: sim/periph_pin_model.sv
// peripheral drive sources and external pin drivers around the mux
module periph_pin_model (
  // design pin drive, used to resolve the wire level
  input wire logic [11:0] pinOut,
  input wire logic [11:0] pinOe,
  // patterns chosen by the bench
  input wire logic [39:0] driveWord,
  input wire logic [11:0] pinWord,
  // toward the design
  output port_mux_pkg::periph_drive_s periphDrive,
  output logic [11:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;

  assign periphDrive = port_mux_pkg::periph_drive_s'(driveWord);

  // design drive wins where enabled, else the outside driver
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      pinIn[i] = pinOe[i] ? pinOut[i] : pinWord[i];
    end
  end
endmodule : periph_pin_model

// file: sim/port_function_select_mux_tb.sv
// apb register and pin routing bench of the port function mux
module port_function_select_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] gpioOut = 12'h6d9;
  logic [11:0] gpioOe = 12'h3b4;
  logic [11:0] gpioIn;
  port_mux_pkg::periph_drive_s periphDrive;
  port_mux_pkg::periph_in_s periphIn;
  logic [11:0] pinIn;
  logic [11:0] pinOut;
  logic [11:0] pinOe;
  logic [39:0] driveWord = 40'h96_c35a_0fe1;
  logic [11:0] pinWord = 12'h5a3;
  int err_count = 0;
  int check_count = 0;
  // peripheral field per pin slot for codes 1..3, -1 keeps the port
  localparam int SRC [12][3] = '{'{9, 1, -1}, '{8, 4, -1}, '{7, 3, -1},
    '{2, 0, -1}, '{6, 13, 18}, '{5, 12, 19}, '{4, 11, -1}, '{3, 10, -1},
    '{14, -1, -1}, '{15, -1, -1}, '{16, -1, -1}, '{17, -1, -1}};
  localparam logic [31:0] ADDR [3] = '{port_mux_pkg::ADDR_PORT1_HIGH,
    port_mux_pkg::ADDR_PORT2_LOW, port_mux_pkg::ADDR_PORT2_HIGH};

  always #5 clk = ~clk;

  port_function_select_mux u_port_function_select_mux (.clk(clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .gpioIn(gpioIn), .periphDrive(periphDrive), .periphIn(periphIn),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));

  periph_pin_model u_periph_pin_model (.pinOut(pinOut), .pinOe(pinOe),
    .driveWord(driveWord), .pinWord(pinWord), .periphDrive(periphDrive),
    .pinIn(pinIn));

  task automatic close_out;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic cmp_val(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_flag(input string what, input logic got,
                          input logic exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : cmp_flag

  // one transfer; pready and data are taken at the same edge
  task automatic apb(input logic wr, input logic [31:0] addr,
                     input logic [31:0] data, input logic [3:0] strb,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    pstrb <= strb;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("unexpected at %0t: no bus answer", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reg_wr(input logic [31:0] a, input logic [7:0] d,
                        input logic [3:0] s, input logic expErr);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, {24'h00_0000, d}, s, rd, e);
    cmp_flag("write error", e, expErr);
  endtask : reg_wr

  task automatic reg_rd(input logic [31:0] a, input logic [7:0] d,
                        input logic expErr);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0000_0000, 4'h0, rd, e);
    cmp_val("read data", rd, {24'h00_0000, d});
    cmp_flag("read error", e, expErr);
  endtask : reg_rd

  // all pins on one code; port for reserved codes
  task automatic check_pins(input int code);
    logic [11:0] eo;
    logic [11:0] ee;
    logic [19:0] ep;
    logic lvl;
    int s;
    repeat (8) @(posedge clk);
    ep = 20'h0_0000;
    for (int p = 0; p < 12; p++) begin
      s = (code == 0) ? -1 : SRC[p][code - 1];
      eo[p] = (s < 0) ? gpioOut[p] : driveWord[(19 - s) * 2 + 1];
      ee[p] = (s < 0) ? gpioOe[p] : driveWord[(19 - s) * 2];
      lvl = ee[p] ? eo[p] : pinWord[p];
      if (s >= 0) begin
        ep[19 - s] = ep[19 - s] | lvl;
      end
    end
    cmp_val("pin out", {20'h0_0000, pinOut}, {20'h0_0000, eo});
    cmp_val("pin oe", {20'h0_0000, pinOe}, {20'h0_0000, ee});
    cmp_val("periph in", {12'h000, periphIn}, {12'h000, ep});
    cmp_val("gpio in", {20'h0_0000, gpioIn},
            {20'h0_0000, (ee & eo) | (~ee & pinWord)});
  endtask : check_pins

  initial begin
    logic [1:0] c;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (int r = 0; r < 3; r++) begin
      reg_rd(ADDR[r], 8'h00, 1'b0);
    end
    check_pins(0);
    reg_rd(port_mux_pkg::ADDR_PORT2_HIGH + 32'h0000_0004, 8'h00,
           1'b1);
    reg_wr(32'h0000_0000, 8'h55, 4'h1, 1'b1);
    // buzzer on pin twenty, seen two edges after the write edge
    reg_wr(port_mux_pkg::ADDR_PORT2_LOW, 8'h03, 4'h1, 1'b0);
    @(posedge clk);
    cmp_flag("pin20 old", pinOut[4], gpioOut[4]);
    @(posedge clk);
    cmp_flag("pin20 new", pinOut[4], driveWord[3]);
    cmp_flag("pin20 oe", pinOe[4], driveWord[2]);
    // disabled byte lane leaves the register alone
    reg_wr(port_mux_pkg::ADDR_PORT2_LOW, 8'hff, 4'h0, 1'b0);
    reg_rd(port_mux_pkg::ADDR_PORT2_LOW, 8'h03, 1'b0);
    for (int code = 0; code < 4; code++) begin
      for (int k = 0; k < 2; k++) begin
        c = code[1:0];
        driveWord <= ~driveWord;
        pinWord <= ~pinWord;
        gpioOut <= ~gpioOut;
        for (int r = 0; r < 3; r++) begin
          reg_wr(ADDR[r], {c, c, c, c}, 4'h1, 1'b0);
          reg_rd(ADDR[r], {c, c, c, c}, 1'b0);
        end
        check_pins(code);
      end
    end
    // second reset in mid-run clears every field
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int r = 0; r < 3; r++) begin
      reg_rd(ADDR[r], 8'h00, 1'b0);
    end
    check_pins(0);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : port_function_select_mux_tb
